// >>> inc/otg_xcvr_pkg.sv
// Contract
// [R1] Single-ended transmit: 00 gives DP0 DN1, 10 gives DP1 DN0, minus 1 forces both low.
// [R2] Pair transmit, suspended drivers: copy plus to DP, minus to DN, receive out 0.
// [R3] Output-enable interrupt bit and suspend both set turn the OE ball into interrupt output.
// [R4] Reception needs uart off, oe-int on; pair mode mirrors lines; receive shows diff receiver.
// [R5] Single-ended receive: minus high only on SE0; plus follows DP or diff receiver.
// [R6] Uart enable routes minus ball to DN and DP to plus ball.
// [R7] Outside uart mode both level-translation paths stay disabled.
// [R8] Provide bus valid, session valid and session end indications.
// [R9] Controller ignores bus valid during power-up.
// [R10] A-device controller treats slow VBUS rise as over-current and ends session.
// [R11] Controller sets pull-downs per A-device role.
// [R12] Each data-line pull-down follows its own control bit.
// [R13] Controller may drop both pull-downs during a packet.
// [R14] DP and DN pull-ups follow two separate control bits.
// [R15] VBUS discharge bit switches the discharge pull-down onto VBUS.
// [R16] Controller waits session end plus 2 ms SE0 before new session.
// [R17] Controller pulses DP pull-up 5 to 10 ms, never DN.
// [R18] Data-line pulsing before VBUS pulsing; assert line within 100 ms of session valid.
// [R19] Controller waits at least 5 s for response before reporting failure.
// [R20] Controller ends VBUS pulsing in time; session valid tells host types apart.
// [R21] Report ID state through ground and float comparator indications.
// [R22] ID-ground bit closes the ID grounding switch.
// [R23] Flag car-kit interrupt when DP drops below car-kit threshold.
// [R24] VBUS drive bit enables the charge pump.
// [R25] Controller derives pulse and timeout durations from a known-clock counter.
package otg_xcvr_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] ctrl1_addr = 4'h1;
   localparam logic [3:0] ctrl2_addr = 4'h2;
   localparam logic [3:0] status_addr = 4'h3;
   localparam logic [3:0] irq_addr = 4'h4;
   localparam logic [7:0] ctrl1_reset = 8'h00;
   localparam logic [7:0] ctrl2_reset = 8'h00;
   // Control 1 fields
   localparam int se_mode_bit = 0;
   localparam int suspend_bit = 1;
   localparam int oe_irq_en_bit = 2;
   localparam int uart_en_bit = 3;
   // Control 2 fields
   localparam int plus_pd_bit = 0;
   localparam int minus_pd_bit = 1;
   localparam int plus_pu_bit = 2;
   localparam int minus_pu_bit = 3;
   localparam int discharge_bit = 4;
   localparam int ident_gnd_bit = 5;
   localparam int vbus_drv_bit = 6;
   // Status fields; the car-kit bit sits in the interrupt register
   localparam int bus_valid_bit = 0;
   localparam int sess_valid_bit = 1;
   localparam int sess_end_bit = 2;
   localparam int ident_low_bit = 3;
   localparam int ident_float_bit = 4;
   localparam int carkit_bit = 5;
endpackage

// >>> rtl/line_mapper.sv
`timescale 1ns/1ns
module line_mapper (
   // Modes
   input wire logic se_mode,
   input wire logic suspend,
   input wire logic rx_allowed,
   // Processor side
   input wire logic tx_plus,
   input wire logic tx_minus,
   // Cable side
   input wire logic dp_in,
   input wire logic dn_in,
   input wire logic diff_rx,
   // Results
   output logic dp_drv,
   output logic dn_drv,
   output logic rx_plus,
   output logic rx_minus,
   output logic rx_diff
);
   always_comb begin
      if (se_mode) begin
         dp_drv = tx_plus & ~tx_minus; // see [R1]
         dn_drv = ~tx_plus & ~tx_minus; // see [R1]
      end else begin
         dp_drv = tx_plus; // see [R2]
         dn_drv = tx_minus; // see [R2]
      end
   end

   always_comb begin
      rx_plus = 1'b0;
      rx_minus = 1'b0;
      rx_diff = 1'b0;
      if (rx_allowed) begin // see [R4]
         if (se_mode) begin
            rx_minus = ~dp_in & ~dn_in; // see [R5]
            rx_plus = (dp_in == dn_in && !suspend) ? diff_rx : dp_in; // see [R5]
         end else begin
            rx_plus = dp_in; // see [R4]
            rx_minus = dn_in; // see [R4]
            rx_diff = suspend ? 1'b0 : diff_rx; // see [R4]
         end
      end
   end
endmodule

// >>> rtl/otg_xcvr_ctrl.sv
`timescale 1ns/1ns
module otg_xcvr_ctrl
   import otg_xcvr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Processor line balls
   input wire logic plus_line_io_in,
   output logic plus_line_io_out,
   output logic plus_line_io_oe,
   input wire logic minus_line_io_in,
   output logic minus_line_io_out,
   output logic minus_line_io_oe,
   output logic diff_receive_out,
   input wire logic output_enable_ball_in,
   output logic output_enable_ball_out,
   output logic output_enable_ball_oe,
   // Cable data lines
   input wire logic dp_in,
   input wire logic dn_in,
   input wire logic diff_rx,
   output logic dp_out,
   output logic dp_oe,
   output logic dn_out,
   output logic dn_oe,
   // Analog controls and comparators
   input wire logic bus_valid_cmp,
   input wire logic sess_valid_cmp,
   input wire logic sess_end_cmp,
   input wire logic ident_low_cmp,
   input wire logic ident_float_cmp,
   input wire logic carkit_below_cmp,
   output logic plus_pd_ctl,
   output logic minus_pd_ctl,
   output logic plus_pu_ctl,
   output logic minus_pu_ctl,
   output logic bus_power_discharge_en,
   output logic ident_ground_switch,
   output logic charge_pump_en,
   output logic uart_tx_path_en,
   output logic uart_rx_path_en
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic carkit_irq_flag_q;
   logic [7:0] status_w;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic se_mode;
   logic suspend;
   logic oe_irq_en;
   logic uart_en;
   logic rx_allowed;
   logic irq_mode;
   logic dp_drv;
   logic dn_drv;
   logic rx_plus;
   logic rx_minus;
   logic rx_diff;

   assign se_mode = ctrl1_q[se_mode_bit];
   assign suspend = ctrl1_q[suspend_bit];
   assign oe_irq_en = ctrl1_q[oe_irq_en_bit];
   assign uart_en = ctrl1_q[uart_en_bit];
   assign rx_allowed = ~uart_en & oe_irq_en; // see [R4]
   assign irq_mode = oe_irq_en & suspend; // see [R3]

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl1_q <= ctrl1_reset;
      end else if (reg_wr && reg_addr == ctrl1_addr) begin
         ctrl1_q <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl2_q <= ctrl2_reset;
      end else if (reg_wr && reg_addr == ctrl2_addr) begin
         ctrl2_q <= reg_wdata;
      end
   end

   // Sticky car-kit flag; a new event beats a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         carkit_irq_flag_q <= 1'b0;
      end else if (carkit_below_cmp) begin
         carkit_irq_flag_q <= 1'b1; // see [R23]
      end else if (reg_wr && reg_addr == irq_addr && reg_wdata[carkit_bit]) begin
         carkit_irq_flag_q <= 1'b0;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      status_w = 8'h00;
      status_w[bus_valid_bit] = bus_valid_cmp; // see [R8]
      status_w[sess_valid_bit] = sess_valid_cmp; // see [R8]
      status_w[sess_end_bit] = sess_end_cmp; // see [R8]
      status_w[ident_low_bit] = ident_low_cmp; // see [R21]
      status_w[ident_float_bit] = ident_float_cmp; // see [R21]
   end

   always_comb begin
      case (reg_addr)
         ctrl1_addr: rdata_d = ctrl1_q;
         ctrl2_addr: rdata_d = ctrl2_q;
         status_addr: rdata_d = status_w;
         irq_addr: rdata_d = {2'h0, carkit_irq_flag_q, 5'h00};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // ****************************************
   // Line mapping
   // ****************************************
   line_mapper u_map (
      .se_mode(se_mode),
      .suspend(suspend),
      .rx_allowed(rx_allowed),
      .tx_plus(plus_line_io_in),
      .tx_minus(minus_line_io_in),
      .dp_in(dp_in),
      .dn_in(dn_in),
      .diff_rx(diff_rx),
      .dp_drv(dp_drv),
      .dn_drv(dn_drv),
      .rx_plus(rx_plus),
      .rx_minus(rx_minus),
      .rx_diff(rx_diff)
   );

   // Cable drivers: outside uart mode, OE ball low (active) enables transmit; as an interrupt output the drivers stay on
   always_comb begin
      dp_out = 1'b0;
      dp_oe = 1'b0;
      dn_out = 1'b0;
      dn_oe = 1'b0;
      if (uart_en) begin
         dn_out = minus_line_io_in; // see [R6]
         dn_oe = 1'b1; // see [R6]
      end else if (irq_mode || !output_enable_ball_in) begin
         dp_out = dp_drv;
         dn_out = dn_drv;
         dp_oe = 1'b1;
         dn_oe = 1'b1;
      end
   end

   // Processor balls
   always_comb begin
      plus_line_io_out = 1'b0;
      plus_line_io_oe = 1'b0;
      minus_line_io_out = 1'b0;
      minus_line_io_oe = 1'b0;
      if (uart_en) begin
         plus_line_io_out = dp_in; // see [R6]
         plus_line_io_oe = 1'b1; // see [R6]
      end else if (rx_allowed && output_enable_ball_in && !irq_mode) begin
         plus_line_io_out = rx_plus;
         minus_line_io_out = rx_minus;
         plus_line_io_oe = 1'b1;
         minus_line_io_oe = 1'b1;
      end
   end

   assign diff_receive_out = rx_diff; // see [R2]
   // Interrupt is active low; the car-kit flag is the event source
   assign output_enable_ball_oe = irq_mode; // see [R3]
   assign output_enable_ball_out = ~carkit_irq_flag_q; // see [R3]
   assign uart_tx_path_en = uart_en; // see [R7]
   assign uart_rx_path_en = uart_en; // see [R7]

   // ****************************************
   // Analog enables
   // ****************************************
   assign plus_pd_ctl = ctrl2_q[plus_pd_bit]; // see [R12]
   assign minus_pd_ctl = ctrl2_q[minus_pd_bit]; // see [R12]
   assign plus_pu_ctl = ctrl2_q[plus_pu_bit]; // see [R14]
   assign minus_pu_ctl = ctrl2_q[minus_pu_bit]; // see [R14]
   assign bus_power_discharge_en = ctrl2_q[discharge_bit]; // see [R15]
   assign ident_ground_switch = ctrl2_q[ident_gnd_bit]; // see [R22]
   assign charge_pump_en = ctrl2_q[vbus_drv_bit]; // see [R24]
endmodule

// >>> testbench/xcvr_monitor.sv
`timescale 1ns/1ns
module xcvr_monitor
   import otg_xcvr_pkg::*;
(
   // Watched ports
   input wire logic core_clk, rst_n, reg_wr, reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata, reg_rdata,
   input wire logic plus_line_io_in, minus_line_io_in, output_enable_ball_in, dp_in, dn_in, diff_rx,
   input wire logic plus_line_io_out, minus_line_io_out, diff_receive_out, output_enable_ball_oe,
   input wire logic dp_out, dn_out, dp_oe, bus_valid_cmp, sess_valid_cmp, sess_end_cmp, carkit_below_cmp,
   input wire logic ident_low_cmp, ident_float_cmp, plus_pd_ctl, minus_pd_ctl, plus_pu_ctl, minus_pu_ctl,
   input wire logic bus_power_discharge_en, ident_ground_switch, charge_pump_en, uart_tx_path_en, uart_rx_path_en
);
   // ****************************************
   // Mode shadow
   // ****************************************
   logic [3:0] c1_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         c1_q <= 4'h0;
      end else if (reg_wr && reg_addr == ctrl1_addr) begin
         c1_q <= reg_wdata[3:0];
      end
   end
   wire se = c1_q[se_mode_bit];
   wire su = c1_q[suspend_bit];
   wire irq = c1_q[oe_irq_en_bit] && su;
   wire txm = !c1_q[uart_en_bit] && (irq || !output_enable_ball_in);
   wire rxm = !c1_q[uart_en_bit] && c1_q[oe_irq_en_bit] && !irq && output_enable_ball_in;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_c2_wr;
      reg_wr && reg_addr == ctrl2_addr;
   endsequence
   sequence s_stat_rd;
      reg_rd && reg_addr == status_addr;
   endsequence
   a_se_tx: assert property (txm && se |-> dp_oe && dp_out == (plus_line_io_in && !minus_line_io_in)
      && dn_out == (!plus_line_io_in && !minus_line_io_in)) else $error("single-ended drive wrong");
   a_pair_tx: assert property (txm && !se && su |-> dp_out == plus_line_io_in && dn_out == minus_line_io_in
      && !diff_receive_out) else $error("pair drive wrong");
   a_irq_ball: assert property (output_enable_ball_oe == irq) else $error("enable ball direction wrong");
   a_pair_rx: assert property (rxm && !se |-> plus_line_io_out == dp_in && minus_line_io_out == dn_in
      && diff_receive_out == diff_rx) else $error("pair receive wrong");
   a_se_rx: assert property (rxm && se |-> minus_line_io_out == (!dp_in && !dn_in)
      && plus_line_io_out == ((dp_in == dn_in) ? diff_rx : dp_in)) else $error("single-ended receive wrong");
   a_uart_route: assert property (c1_q[uart_en_bit] |-> dn_out == minus_line_io_in && plus_line_io_out == dp_in)
      else $error("uart routing wrong");
   a_uart_paths: assert property (uart_tx_path_en == c1_q[uart_en_bit] && uart_rx_path_en == c1_q[uart_en_bit])
      else $error("translator enable wrong");
   a_ctrl2_out: assert property (s_c2_wr |=> {charge_pump_en, ident_ground_switch, bus_power_discharge_en,
      minus_pu_ctl, plus_pu_ctl, minus_pd_ctl, plus_pd_ctl} == $past(reg_wdata[6:0]))
      else $error("analog control wrong");
   a_status_read: assert property ($stable({ident_float_cmp, ident_low_cmp, sess_end_cmp, sess_valid_cmp,
      bus_valid_cmp}) and s_stat_rd |=> reg_rdata[4:0] == $past({ident_float_cmp, ident_low_cmp, sess_end_cmp,
      sess_valid_cmp, bus_valid_cmp})) else $error("status read wrong");
   a_carkit_flag: assert property (carkit_below_cmp [*3] ##1 (reg_rd && reg_addr == irq_addr)
      |=> reg_rdata[carkit_bit]) else $error("car-kit flag missing");
endmodule
bind otg_xcvr_ctrl xcvr_monitor mon (.*);

// >>> testbench/proc_ctl_model.sv
`timescale 1ns/1ns
module proc_ctl_model (
   // Controller intent
   input wire logic tx_p, tx_m, tx_en,
   // Transceiver side of the balls
   input wire logic plus_line_io_out, plus_line_io_oe, minus_line_io_out, minus_line_io_oe,
   input wire logic output_enable_ball_out, output_enable_ball_oe,
   output logic plus_line_io_in, minus_line_io_in, output_enable_ball_in
);
   // ****************************************
   // Ball levels
   // ****************************************
   // Session timing duties of the controller stay outside this model
   // Released line balls show tx_p and tx_m inverted only while tx_en is low; the released OE ball shows the inverse of tx_en
   assign plus_line_io_in = plus_line_io_oe ? plus_line_io_out : (tx_en ? tx_p : ~tx_p);
   assign minus_line_io_in = minus_line_io_oe ? minus_line_io_out : (tx_en ? tx_m : ~tx_m);
   assign output_enable_ball_in = output_enable_ball_oe ? output_enable_ball_out : ~tx_en;
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ns
module tb
   import otg_xcvr_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_p = 0, tx_m = 0, tx_en = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v, c1, c2, st;
   logic dp_in = 0, dn_in = 0, diff_rx = 0, bus_valid_cmp = 0, sess_valid_cmp = 0, sess_end_cmp = 0;
   logic ident_low_cmp = 0, ident_float_cmp = 0, carkit_below_cmp = 0, rxm;
   logic plus_line_io_in, plus_line_io_out, plus_line_io_oe, minus_line_io_in, minus_line_io_out;
   logic minus_line_io_oe, diff_receive_out, output_enable_ball_in, output_enable_ball_out;
   logic output_enable_ball_oe, dp_out, dp_oe, dn_out, dn_oe, plus_pd_ctl, minus_pd_ctl, plus_pu_ctl;
   logic minus_pu_ctl, bus_power_discharge_en, ident_ground_switch, charge_pump_en, uart_tx_path_en, uart_rx_path_en;
   int num_errors = 0, n_tests = 0, seed = 70, cyc = 0;
   otg_xcvr_ctrl dut (.*);
   proc_ctl_model partner (.*);
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic [1:0] tx_lines(input logic se, p, m);
      return se ? {p & ~m, ~p & ~m} : {p, m};
   endfunction
   function automatic logic [1:0] rx_balls(input logic se, a, b, d);
      return se ? {(a == b) ? d : a, ~a & ~b} : {a, b};
   endfunction
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(4'h9, rd_v);
      chk(rd_v, 8'h00);
      for (int i = 0; i < 300; i++) begin
         c1 = $random(seed) & 8'h0f;
         c2 = $random(seed) & 8'h7f; // Random pull-down pairs cover every role
         wr(ctrl1_addr, c1);
         wr(ctrl2_addr, c2);
         st = $random(seed) & 8'h1f;
         @(posedge core_clk);
         {dp_in, dn_in, diff_rx, tx_p, tx_m, tx_en} <= 6'($random(seed));
         {ident_float_cmp, ident_low_cmp, sess_end_cmp, sess_valid_cmp, bus_valid_cmp} <= st[4:0];
         @(posedge core_clk);
         #1 rxm = !c1[3] && c1[2] && !c1[1] && !tx_en;
         chk({1'b0, charge_pump_en, ident_ground_switch, bus_power_discharge_en, minus_pu_ctl, plus_pu_ctl,
            minus_pd_ctl, plus_pd_ctl}, c2);
         chk({uart_tx_path_en, uart_rx_path_en, output_enable_ball_oe}, {c1[3], c1[3], c1[2] & c1[1]});
         chk(diff_receive_out, !c1[0] && !c1[3] && c1[2] && !c1[1] && diff_rx);
         if (!c1[3] && (c1[2] && c1[1] || tx_en))
            chk({dp_out, dn_out, dp_oe, dn_oe}, {tx_lines(c1[0], plus_line_io_in, minus_line_io_in), 2'b11});
         if (rxm)
            chk({plus_line_io_out, minus_line_io_out, plus_line_io_oe}, {rx_balls(c1[0], dp_in, dn_in, diff_rx), 1'b1});
         rd(status_addr, rd_v);
         chk(rd_v & 8'h1f, st);
      end
      carkit_below_cmp <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(irq_addr, rd_v);
      chk(rd_v[5], 1'b1);
      wr(ctrl1_addr, 8'h06);
      @(posedge core_clk);
      #1 chk({output_enable_ball_oe, output_enable_ball_out}, 2'b10);
      carkit_below_cmp <= 1'b0;
      wr(irq_addr, 8'h20);
      rd(irq_addr, rd_v);
      chk(rd_v[5], 1'b0);
      give_verdict();
   end
endmodule
